// ==== smp_consts.vh ====
`ifndef SMP_CONSTS_VH
`define SMP_CONSTS_VH
// command codes
`define SMP_CMD_ADDR_WRITE 8'h00
`define SMP_CMD_PTR_READ 8'h80
`define SMP_CMD_ADDR_READ 8'hC0
// status bytes returned when ready and while write busy
`define SMP_STATUS_READY 8'h00
`define SMP_STATUS_BUSY 8'hFF
// array geometry
`define SMP_ARRAY_BITS 2048
`define SMP_ADDR_W 8
`define SMP_DATA_W 8
`define SMP_MAX_WRITE 3
// internal write cycle per byte, in clock cycles
`define SMP_WRITE_CYCLES 16
// session phases
`define SMP_PH_IDLE 3'h0
`define SMP_PH_CMD 3'h1
`define SMP_PH_STAT 3'h2
`define SMP_PH_ADDR 3'h3
`define SMP_PH_WDATA 3'h4
`define SMP_PH_RDATA 3'h5
`define SMP_PH_DEAD 3'h6
`endif

// ==== smp_sync.v ====
`timescale 1ns/1ns
`include "smp_consts.vh"
module smp_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // raw and synchronised levels
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff;

  // two-stage synchroniser
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule

// ==== smp_serial_memory.v ====
`timescale 1ns/1ns
`include "smp_consts.vh"
// Behaviour
// [R1] master holds chip_enable high throughout every transfer
// [R2] master lowers select_line before lowering chip_enable
// [R3] both chip_enable and select_line low gives reduced-power standby
// [R4] data line is open drain: pull low or release only
// [R5] cells untouched while select_line low; operate only while high; the write commit here runs after select_line falls
// [R6] session starts on select_line rise seen while serial clock high
// [R7] master raises select_line before sending any command byte
// [R8] select_line falling ends the session
// [R9] order: command byte, one status byte, then command bytes
// [R10] status byte is 00H when ready, nonzero while write busy
// [R11] master abandons session on nonzero status and retries later
// [R12] write command: pointer byte then up to three data bytes
// [R13] accepted write data committed only after select_line goes low
// [R14] pointer read loads cell, increments pointer after every byte
// [R15] addressed read sets pointer then reads as pointer read
// [R16] master supplies serial clock; memory only receives it
// [R17] array holds 2048 bits as bytes addressed by pointer
// [R18] command byte sent most significant bit first
// [R19] address and data bytes msb first, eight clocks each
module smp_serial_memory #(
  parameter ADDR_W = `SMP_ADDR_W,
  parameter DATA_W = `SMP_DATA_W,
  parameter WRITE_CYCLES = `SMP_WRITE_CYCLES
) (
  // system
  input wire clk,
  input wire arst_n,
  // link pins
  input wire chip_enable,
  input wire select_line,
  input wire serial_clock_line,
  input wire sda_in,
  output reg sda_out_ff,
  output reg sda_oe_ff,
  // status
  output reg standby_ff,
  output reg write_busy_ff
);
  localparam DEPTH = `SMP_ARRAY_BITS / DATA_W; // [R17]
  localparam [2:0] PH_IDLE = `SMP_PH_IDLE;
  localparam [2:0] PH_CMD = `SMP_PH_CMD;
  localparam [2:0] PH_STAT = `SMP_PH_STAT;
  localparam [2:0] PH_ADDR = `SMP_PH_ADDR;
  localparam [2:0] PH_WDATA = `SMP_PH_WDATA;
  localparam [2:0] PH_RDATA = `SMP_PH_RDATA;
  localparam [2:0] PH_DEAD = `SMP_PH_DEAD;

  wire ce_s;
  wire cs_s;
  wire sck_s;
  wire sda_s;
  reg cs_d_ff;
  reg sck_d_ff;
  reg [2:0] phase_ff;
  reg [2:0] nxt_phase;
  reg [2:0] bit_cnt_ff;
  reg [DATA_W-1:0] shift_ff;
  reg [DATA_W-1:0] tx_ff;
  reg [7:0] cmd_ff;
  reg [ADDR_W-1:0] ptr_ff;
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  reg [DATA_W-1:0] wbuf_ff [0:`SMP_MAX_WRITE-1];
  reg [1:0] wcnt_ff;
  reg [ADDR_W-1:0] waddr_ff;
  reg [1:0] commit_left_ff;
  reg [1:0] commit_idx_ff;
  reg [15:0] wtimer_ff;
  reg commit_pend_ff;

  // pins enter through two flip-flops
  smp_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({chip_enable, select_line, serial_clock_line, sda_in}),
    .dout({ce_s, cs_s, sck_s, sda_s})
  );

  // edge detection on synchronised levels; master owns the clock [R16]
  wire sck_rise = sck_s & ~sck_d_ff;
  wire sck_fall = ~sck_s & sck_d_ff;
  wire cs_rise = cs_s & ~cs_d_ff;
  wire cs_fall = ~cs_s & cs_d_ff;
  wire [DATA_W-1:0] rx_byte = {shift_ff[DATA_W-2:0], sda_s}; // [R18] [R19]
  wire byte_done = sck_rise & (bit_cnt_ff == 3'h7);
  wire busy_now = commit_pend_ff | write_busy_ff;
  wire [ADDR_W-1:0] ptr_inc = ptr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};

  // session phase sequencing
  always @* begin
    nxt_phase = phase_ff;
    if (!cs_s) begin
      nxt_phase = PH_IDLE; // [R8] [R5]
    end else if (cs_rise && sck_s) begin
      nxt_phase = PH_CMD; // [R6]
    end else if (byte_done) begin
      case (phase_ff)
        PH_CMD: nxt_phase = PH_STAT; // [R9]
        PH_STAT: begin
          if (busy_now) begin
            nxt_phase = PH_DEAD;
          end else if (cmd_ff == `SMP_CMD_PTR_READ) begin
            nxt_phase = PH_RDATA; // [R14]
          end else if (cmd_ff == `SMP_CMD_ADDR_WRITE || cmd_ff == `SMP_CMD_ADDR_READ) begin
            nxt_phase = PH_ADDR; // [R12] [R15]
          end else begin
            nxt_phase = PH_DEAD;
          end
        end
        PH_ADDR: nxt_phase = (cmd_ff == `SMP_CMD_ADDR_READ) ? PH_RDATA : PH_WDATA; // [R15]
        PH_WDATA: nxt_phase = (wcnt_ff == 2'h2) ? PH_DEAD : PH_WDATA; // [R12]
        default: nxt_phase = phase_ff;
      endcase
    end
  end

  // shifter, pointer and command capture
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_d_ff <= 1'b0;
      sck_d_ff <= 1'b0;
      phase_ff <= PH_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff <= {DATA_W{1'b0}};
      tx_ff <= {DATA_W{1'b1}};
      cmd_ff <= 8'h00;
      ptr_ff <= {ADDR_W{1'b0}};
      wcnt_ff <= 2'h0;
      waddr_ff <= {ADDR_W{1'b0}};
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      cs_d_ff <= cs_s;
      sck_d_ff <= sck_s;
      phase_ff <= nxt_phase;
      sda_out_ff <= 1'b0; // [R4]
      if (nxt_phase != phase_ff || !cs_s) begin
        bit_cnt_ff <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
      if (sck_rise) begin
        shift_ff <= rx_byte;
      end
      if (cs_rise) begin
        wcnt_ff <= 2'h0;
      end
      if (byte_done) begin
        case (phase_ff)
          PH_CMD: begin
            cmd_ff <= rx_byte;
            tx_ff <= busy_now ? `SMP_STATUS_BUSY : `SMP_STATUS_READY; // [R10]
          end
          PH_STAT: tx_ff <= mem[ptr_ff]; // [R14]
          PH_ADDR: begin
            ptr_ff <= rx_byte; // [R12] [R15]
            waddr_ff <= rx_byte;
            tx_ff <= mem[rx_byte]; // [R15]
          end
          PH_WDATA: begin
            wcnt_ff <= wcnt_ff + 2'h1;
          end
          PH_RDATA: begin
            ptr_ff <= ptr_inc; // [R14]
            tx_ff <= mem[ptr_inc];
          end
          default: tx_ff <= tx_ff;
        endcase
      end else if (sck_fall && bit_cnt_ff != 3'h0 &&
                   (phase_ff == PH_STAT || phase_ff == PH_RDATA)) begin
        tx_ff <= {tx_ff[DATA_W-2:0], 1'b1};
      end
      // only pull low on a zero bit, release otherwise [R4]
      sda_oe_ff <= cs_s && (phase_ff == PH_STAT || phase_ff == PH_RDATA) && !tx_ff[DATA_W-1]; // [R4]
    end
  end

  // write buffer capture during the session
  always @(posedge clk) begin
    if (byte_done && phase_ff == PH_WDATA) begin
      wbuf_ff[wcnt_ff] <= rx_byte; // [R12]
    end
  end

  // internal write cycle after select_line falls
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      commit_pend_ff <= 1'b0;
      commit_left_ff <= 2'h0;
      commit_idx_ff <= 2'h0;
      wtimer_ff <= 16'h0000;
      write_busy_ff <= 1'b0;
    end else begin
      if (cs_fall && cmd_ff == `SMP_CMD_ADDR_WRITE && wcnt_ff != 2'h0 && !write_busy_ff) begin
        commit_pend_ff <= 1'b1; // [R13]
        commit_left_ff <= wcnt_ff;
        commit_idx_ff <= 2'h0;
        wtimer_ff <= WRITE_CYCLES[15:0];
        write_busy_ff <= 1'b1;
      end else if (write_busy_ff) begin
        commit_pend_ff <= 1'b0;
        if (wtimer_ff != 16'h0000) begin
          wtimer_ff <= wtimer_ff - 16'h0001;
        end else if (commit_left_ff != 2'h0) begin
          commit_left_ff <= commit_left_ff - 2'h1;
          commit_idx_ff <= commit_idx_ff + 2'h1;
          wtimer_ff <= WRITE_CYCLES[15:0];
        end else begin
          write_busy_ff <= 1'b0;
        end
      end
    end
  end

  // array update, one byte per write cycle
  always @(posedge clk) begin
    if (write_busy_ff && wtimer_ff == 16'h0000 && commit_left_ff != 2'h0) begin
      mem[waddr_ff + {6'h00, commit_idx_ff}] <= wbuf_ff[commit_idx_ff]; // [R13] [R12]
    end
  end

  // standby indication
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_ff <= 1'b0;
    end else begin
      standby_ff <= !ce_s && !cs_s; // [R3]
    end
  end
endmodule

// ==== smp_chk.sv ====
`timescale 1ns/1ns
module smp_chk #(
  parameter WRITE_CYCLES = 16
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // pins and status
  input wire chip_enable,
  input wire select_line,
  input wire serial_clock_line,
  input wire sda_out_ff,
  input wire sda_oe_ff,
  input wire standby_ff,
  input wire write_busy_ff
);
  localparam int BMAX = 4 * WRITE_CYCLES + 40;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // standby, drive and frame
  a_standby_set: assert property ((!chip_enable && !select_line)[*5] |-> standby_ff) else $error("standby");
  a_standby_clr: assert property (chip_enable[*5] |-> !standby_ff) else $error("awake");
  a_drain_only: assert property (!sda_out_ff) else $error("drive high");
  a_oe_in_frame: assert property ($rose(sda_oe_ff) |-> $past(select_line, 2)) else $error("frame");
  a_idle_release: assert property ((!select_line)[*6] |-> !sda_oe_ff) else $error("release");
  a_oe_steady: assert property ((select_line && serial_clock_line)[*4] |-> $stable(sda_oe_ff)) else $error("bit moved");
  // commit timing
  a_commit_late: assert property ($rose(write_busy_ff) |-> !select_line) else $error("early");
  a_commit_ends: assert property ($rose(write_busy_ff) |-> ##[1:BMAX] !write_busy_ff) else $error("hang");
  c_commit: cover property ($rose(write_busy_ff));
  c_drive: cover property ($rose(sda_oe_ff));
  c_wake: cover property ($fell(standby_ff));
endmodule
bind smp_serial_memory smp_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.clk(clk), .arst_n(arst_n),
  .chip_enable(chip_enable), .select_line(select_line), .serial_clock_line(serial_clock_line),
  .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .standby_ff(standby_ff), .write_busy_ff(write_busy_ff));

// ==== smp_mst.sv ====
`timescale 1ns/1ns
module smp_mst (
  // master pins
  output logic chip_enable,
  output logic select_line,
  output logic serial_clock_line,
  output logic sda_low,
  // resolved line
  input wire sda
);
  // idle: clock high, line released
  initial begin
    chip_enable = 1'b0;
    select_line = 1'b0;
    serial_clock_line = 1'b1;
    sda_low = 1'b0;
  end
  // enable moves only outside frames
  task automatic power(input logic on);
    chip_enable = on;
  endtask
  // one byte msb first, sampled late in high phase
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_clock_line = 1'b0;
      sda_low = ~tx[i];
      #80 serial_clock_line = 1'b1;
      #60 rx[i] = sda;
      #20;
    end
    sda_low = 1'b0;
  endtask
  // open with clock high, command, status
  task automatic open_s(input logic [7:0] cmd, output logic [7:0] st);
    logic [7:0] d;
    select_line = 1'b1;
    #80 xb(cmd, d);
    xb(8'hFF, st);
  endtask
  // close frame
  task automatic close_s();
    select_line = 1'b0;
    #160;
  endtask
endmodule

// ==== test_serial_memory_3wire_protocol.sv ====
`timescale 1ns/1ns
`include "smp_consts.vh"
module test_serial_memory_3wire_protocol;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] st;
  logic [7:0] d;
  int n_errors = 0;
  int checked = 0;
  wire ce, sel, sck, sda_low, sda_out_ff, sda_oe_ff, standby_ff, write_busy_ff;
  // open-drain line with pull-up
  wire sda = !sda_low && !(sda_oe_ff && !sda_out_ff);
  // 50 MHz clock
  initial forever #10 clk = ~clk;
  smp_mst mst (.chip_enable(ce), .select_line(sel), .serial_clock_line(sck), .sda_low(sda_low), .sda(sda));
  smp_serial_memory #(.WRITE_CYCLES(40)) uut (.clk(clk), .arst_n(arst_n), .chip_enable(ce),
    .select_line(sel), .serial_clock_line(sck), .sda_in(sda), .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff), .standby_ff(standby_ff), .write_busy_ff(write_busy_ff));
  // byte compare
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // verdict
  task automatic close_out();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // wait for commit end
  task automatic wait_idle();
    for (int i = 0; i < 400 && write_busy_ff !== 1'b0; i++) @(negedge clk);
    cmp8({7'h00, write_busy_ff}, 8'h00);
  endtask
  // standby follows enable
  task automatic t_standby();
    repeat (6) @(negedge clk);
    cmp8({7'h00, standby_ff}, 8'h01);
    mst.power(1'b1);
    repeat (6) @(negedge clk);
    cmp8({7'h00, standby_ff}, 8'h00);
  endtask
  // write n bytes counting up from v at a
  task automatic t_write(input logic [7:0] a, input int n, input logic [7:0] v);
    mst.open_s(`SMP_CMD_ADDR_WRITE, st);
    cmp8(st, `SMP_STATUS_READY);
    mst.xb(a, d);
    for (int i = 0; i < n; i++) mst.xb(v + i[7:0], d);
    cmp8({7'h00, write_busy_ff}, 8'h00);
    mst.close_s();
    cmp8({7'h00, write_busy_ff}, 8'h01);
  endtask
  // session during commit
  task automatic t_busy();
    cmp8({7'h00, write_busy_ff}, 8'h01);
    mst.open_s(`SMP_CMD_PTR_READ, st);
    cmp8(st, `SMP_STATUS_BUSY);
    mst.close_s();
  endtask
  // unknown command: ready status, then line left released
  task automatic t_bad();
    mst.open_s(8'h40, st);
    cmp8(st, `SMP_STATUS_READY);
    mst.xb(8'hFF, d);
    cmp8(d, 8'hFF);
    mst.close_s();
  endtask
  // addressed then pointer read
  task automatic t_read();
    mst.open_s(`SMP_CMD_ADDR_READ, st);
    cmp8(st, `SMP_STATUS_READY);
    mst.xb(8'h10, d);
    for (int i = 0; i < 3; i++) begin
      mst.xb(8'hFF, d);
      cmp8(d, 8'hA0 + i[7:0]);
    end
    mst.close_s();
    mst.open_s(`SMP_CMD_PTR_READ, st);
    cmp8(st, `SMP_STATUS_READY);
    mst.xb(8'hFF, d);
    cmp8(d, 8'h5A);
    mst.close_s();
  endtask
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    t_standby();
    t_write(8'h13, 1, 8'h5A);
    wait_idle();
    t_write(8'h10, 4, 8'hA0);
    t_busy();
    wait_idle();
    t_bad();
    t_read();
    close_out();
  end
  // watchdog
  initial begin
    #300000;
    n_errors++;
    close_out();
  end
endmodule
